// ### core/acs_ctrl.sv
// Continuous conversion controller: APB registers, trigger, flags and interrupt
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1: Mode 2 converts chosen channel until stop
// R2: Mode 2 sets done flag, fills result zero
// R3: Writing zero to start stops new launches
// R4: Software reads each result before next overwrite
// R5: Mode 3 walks four slots, sixteen channels
// R6: Length field selects slots zero through N
// R7: Mode 3 repeats sequence until stop
// R8: Each sample lands in slot-indexed result
// R9: Sequence-done flag after each full pass
// R10: Software enables converter, waits for ready
// R11: Software writes mode before start
// R12: Software clears flags before sequence run
// R13: Software stops before changing channel
// R14: Software disables converter after stopping
// R15: Selected trigger starts conversions like start
// R16: Done flag raises interrupt when enabled
// R17: Start stays set; slots wrap to zero
// R18: Running conversion finishes after stop
module acs_ctrl (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    input  wire logic [7:0]   paddr,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic [15:0]  trig_in,
    output logic              conv_enable,
    output logic              conv_start,
    output logic [3:0]        conv_channel,
    output logic [3:0]        conv_sample_speed,
    input  wire logic         conv_done,
    input  wire logic [11:0]  conv_data,
    output logic              irq
);
    typedef struct packed {
        logic                                en;
        logic [2:0]                          mode;
        logic [3:0]                          speed;
        logic [3:0]                          ch_sel;
        logic                                start;
        logic [3:0][3:0]                     slot_ch;
        logic [1:0]                          seq_len;
        logic [3:0]                          trig_sel;
        logic                                trig_en;
        logic [15:0]                         trig_prev;
        logic                                flag_eoc;
        logic                                flag_eos;
        logic                                ready;
        logic [acs_pkg::STARTUP_CW-1:0]      ready_cnt;
        logic [1:0]                          ien;
        logic [3:0][11:0]                    result;
        logic                                rdy;
        logic [31:0]                         rd_data;
        logic                                slverr;
    } acs_ctrl_st_t;

    acs_ctrl_st_t q_r;
    acs_ctrl_st_t q_nxt;

    logic         seq_busy;
    logic [1:0]   seq_slot;
    logic         res_we;
    logic [1:0]   res_idx;
    logic [11:0]  res_data;
    logic         eos_p;
    logic         acc;
    logic         wr;
    logic         trig_hit;
    logic [31:0]  rmux;
    logic         mapped;

    acs_seq u_seq (
        .pclk         (pclk),
        .presetn      (presetn),
        .ce           (ce),
        .enable       (q_r.en),
        .run          (q_r.start),
        .mode         (q_r.mode),
        .seq_len      (q_r.seq_len),
        .ch_single    (q_r.ch_sel),
        .slot_ch      (q_r.slot_ch),
        .conv_done    (conv_done),
        .conv_data    (conv_data),
        .conv_start   (conv_start),
        .conv_channel (conv_channel),
        .busy         (seq_busy),
        .slot         (seq_slot),
        .res_we       (res_we),
        .res_idx      (res_idx),
        .res_data     (res_data),
        .eos_p        (eos_p)
    );

    // One wait state: read data is captured on the same edge that raises pready
    assign acc = psel && penable;
    assign wr  = acc && q_r.rdy && pwrite;

    // R15: rising edge on the chosen source
    assign trig_hit = q_r.trig_en && trig_in[q_r.trig_sel] && !q_r.trig_prev[q_r.trig_sel];

    always_comb begin
        rmux   = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            acs_pkg::OFF_CTRL0: begin
                rmux[acs_pkg::CTRL0_EN_BIT]                           = q_r.en;
                rmux[acs_pkg::CTRL0_MODE_LSB +: 3]                    = q_r.mode;
                rmux[acs_pkg::CTRL0_SPEED_LSB +: 4]                   = q_r.speed;
            end
            acs_pkg::OFF_CTRL1:    rmux[3:0] = q_r.ch_sel;
            acs_pkg::OFF_START:    rmux[0]   = q_r.start;
            acs_pkg::OFF_SEQ_CFG: begin
                rmux[15:0]                           = q_r.slot_ch;
                rmux[acs_pkg::SEQ_LEN_LSB +: 2]      = q_r.seq_len;
            end
            acs_pkg::OFF_TRIG_CFG: begin
                rmux[3:0]                            = q_r.trig_sel;
                rmux[acs_pkg::TRIG_EN_BIT]           = q_r.trig_en;
            end
            acs_pkg::OFF_FLAG: begin
                rmux[acs_pkg::FLAG_EOC_BIT]          = q_r.flag_eoc;
                rmux[acs_pkg::FLAG_EOS_BIT]          = q_r.flag_eos;
                rmux[acs_pkg::FLAG_READY_BIT]        = q_r.ready;
            end
            acs_pkg::OFF_FLAG_CLR: rmux = 32'h0000_0000;
            acs_pkg::OFF_IRQ_EN:   rmux[1:0] = q_r.ien;
            default: begin
                if (paddr >= acs_pkg::OFF_RESULT0 && paddr <= acs_pkg::OFF_RESULT3 && paddr[1:0] == 2'h0) begin
                    rmux[11:0] = q_r.result[paddr[3:2]];
                end else begin
                    mapped = 1'b0;
                end
            end
        endcase
    end

    always_comb begin
        q_nxt           = q_r;
        q_nxt.trig_prev = trig_in;

        // Bus slave: capture in first access cycle, complete in second
        if (acc && !q_r.rdy) begin
            q_nxt.rdy     = 1'b1;
            q_nxt.rd_data = pwrite ? 32'h0000_0000 : rmux;
            q_nxt.slverr  = !mapped;
        end else begin
            q_nxt.rdy     = 1'b0;
            q_nxt.slverr  = 1'b0;
        end

        if (wr) begin
            case (paddr)
                acs_pkg::OFF_CTRL0: begin
                    q_nxt.en    = pwdata[acs_pkg::CTRL0_EN_BIT];
                    q_nxt.mode  = pwdata[acs_pkg::CTRL0_MODE_LSB +: 3];
                    q_nxt.speed = pwdata[acs_pkg::CTRL0_SPEED_LSB +: 4];
                end
                acs_pkg::OFF_CTRL1:    q_nxt.ch_sel = pwdata[3:0];
                // R3: zero stops launching
                acs_pkg::OFF_START:    q_nxt.start = pwdata[0];
                acs_pkg::OFF_SEQ_CFG: begin
                    // R5: four 4-bit slot fields
                    q_nxt.slot_ch = pwdata[15:0];
                    q_nxt.seq_len = pwdata[acs_pkg::SEQ_LEN_LSB +: 2];
                end
                acs_pkg::OFF_TRIG_CFG: begin
                    q_nxt.trig_sel = pwdata[3:0];
                    q_nxt.trig_en  = pwdata[acs_pkg::TRIG_EN_BIT];
                end
                acs_pkg::OFF_FLAG_CLR: begin
                    // Zero in a bit clears that flag, one leaves it
                    if (!pwdata[acs_pkg::FLAG_EOC_BIT]) q_nxt.flag_eoc = 1'b0;
                    if (!pwdata[acs_pkg::FLAG_EOS_BIT]) q_nxt.flag_eos = 1'b0;
                end
                acs_pkg::OFF_IRQ_EN:   q_nxt.ien = pwdata[1:0];
                default: ;
            endcase
        end

        // R17: trigger sets the start bit, which then stays set
        if (trig_hit && q_r.en) begin
            q_nxt.start = 1'b1;
        end

        // Startup delay before the converter reports ready
        if (!q_r.en) begin
            q_nxt.ready     = 1'b0;
            q_nxt.ready_cnt = '0;
        end else if (!q_r.ready) begin
            if (q_r.ready_cnt == acs_pkg::STARTUP_CW'(acs_pkg::STARTUP_CYC - 1)) begin
                q_nxt.ready = 1'b1;
            end else begin
                q_nxt.ready_cnt = acs_pkg::STARTUP_CW'(q_r.ready_cnt + 1'b1);
            end
        end

        // R2: new sample and done flag; set beats a same-cycle clear
        // R8: slot-indexed result store
        if (res_we) begin
            q_nxt.result[res_idx] = res_data;
            q_nxt.flag_eoc        = 1'b1;
        end
        // R9: sequence-done flag
        if (eos_p) begin
            q_nxt.flag_eos = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_r <= '{en: 1'b0, mode: acs_pkg::MODE_RST, speed: 4'h0, ch_sel: acs_pkg::CH_RST, start: 1'b0,
                     slot_ch: 16'h0000, seq_len: acs_pkg::SEQ_LEN_RST, trig_sel: 4'h0, trig_en: 1'b0,
                     trig_prev: 16'h0000, flag_eoc: 1'b0, flag_eos: 1'b0, ready: 1'b0, ready_cnt: '0,
                     ien: 2'h0, result: 48'h0000_0000_0000, rdy: 1'b0, rd_data: 32'h0000_0000,
                     slverr: 1'b0};
        end else if (ce) begin
            q_r <= q_nxt;
        end
    end

    assign prdata            = q_r.rd_data;
    assign pready            = q_r.rdy;
    assign pslverr           = q_r.slverr;
    assign conv_enable       = q_r.en;
    assign conv_sample_speed = q_r.speed;
    // R16: unmasked flags drive the interrupt
    assign irq               = (q_r.flag_eoc && q_r.ien[0]) || (q_r.flag_eos && q_r.ien[1]);

    // Checks assume ce stays high while they are watching

    property p_single_result;
        @(posedge pclk) disable iff (!presetn)
        (ce && seq_busy && conv_done && q_r.en && q_r.mode == acs_pkg::MODE_SINGLE_CONT) ##1 ce ##1 ce
        |-> q_r.flag_eoc && q_r.result[0] == $past(conv_data, 2);
    endproperty
    a_single_result: assert property (p_single_result) else $error("mode 2 sample not in result zero"); // R2

    property p_start_launches;
        @(posedge pclk) disable iff (!presetn)
        (ce && !seq_busy && q_r.start && q_r.en && q_r.mode == acs_pkg::MODE_SINGLE_CONT) |=> conv_start;
    endproperty
    a_start_launches: assert property (p_start_launches) else $error("start did not launch"); // R1

    property p_stop_no_launch;
        @(posedge pclk) disable iff (!presetn)
        conv_start |-> $past(q_r.start);
    endproperty
    a_stop_no_launch: assert property (p_stop_no_launch) else $error("launch without start bit"); // R3

    property p_seq_channel;
        @(posedge pclk) disable iff (!presetn)
        (conv_start && q_r.mode == acs_pkg::MODE_SEQ_CONT) |-> conv_channel == q_r.slot_ch[seq_slot];
    endproperty
    a_seq_channel: assert property (p_seq_channel) else $error("slot channel mismatch"); // R5

    property p_slot_range;
        @(posedge pclk) disable iff (!presetn)
        (seq_busy && q_r.mode == acs_pkg::MODE_SEQ_CONT && $stable(q_r.seq_len)) |-> seq_slot <= q_r.seq_len;
    endproperty
    a_slot_range: assert property (p_slot_range) else $error("slot beyond sequence length"); // R6

    property p_eos_last;
        @(posedge pclk) disable iff (!presetn)
        eos_p |-> res_idx == q_r.seq_len ##1 (!ce || q_r.flag_eos);
    endproperty
    a_eos_last: assert property (p_eos_last) else $error("sequence done at wrong slot"); // R9

    property p_trig_start;
        @(posedge pclk) disable iff (!presetn)
        (ce && trig_hit && q_r.en) |=> q_r.start;
    endproperty
    a_trig_start: assert property (p_trig_start) else $error("trigger did not set start"); // R15

    property p_irq_eoc;
        @(posedge pclk) disable iff (!presetn)
        (ce && res_we && q_r.ien[0] && !(wr && paddr == acs_pkg::OFF_IRQ_EN)) |=> irq;
    endproperty
    a_irq_eoc: assert property (p_irq_eoc) else $error("done flag without interrupt"); // R16

    property p_finish_after_stop;
        @(posedge pclk) disable iff (!presetn)
        (ce && seq_busy && !q_r.start && conv_done && q_r.en) |=> res_we && !seq_busy;
    endproperty
    a_finish_after_stop: assert property (p_finish_after_stop) else $error("last sample lost on stop"); // R18
endmodule : acs_ctrl
`default_nettype wire

// ### pkg/acs_pkg.sv
// Shared constants and types for the continuous conversion controller
package acs_pkg;
    // Timing
    localparam int unsigned PCLK_HZ      = 25_000_000;
    localparam int unsigned STARTUP_NS   = 1000;
    localparam int unsigned STARTUP_CYC  = (STARTUP_NS * (PCLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned STARTUP_CW   = $clog2(STARTUP_CYC + 1);

    // Widths
    localparam int unsigned DATA_W       = 12;
    localparam int unsigned CH_W         = 4;
    localparam int unsigned SLOTS        = 4;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL0     = 8'h00;
    localparam logic [7:0] OFF_CTRL1     = 8'h04;
    localparam logic [7:0] OFF_START     = 8'h08;
    localparam logic [7:0] OFF_SEQ_CFG   = 8'h0c;
    localparam logic [7:0] OFF_TRIG_CFG  = 8'h10;
    localparam logic [7:0] OFF_FLAG      = 8'h14;
    localparam logic [7:0] OFF_FLAG_CLR  = 8'h18;
    localparam logic [7:0] OFF_IRQ_EN    = 8'h1c;
    localparam logic [7:0] OFF_RESULT0   = 8'h20;
    localparam logic [7:0] OFF_RESULT3   = 8'h2c;

    // Field positions
    localparam int unsigned CTRL0_EN_BIT    = 0;
    localparam int unsigned CTRL0_MODE_LSB  = 1;
    localparam int unsigned CTRL0_SPEED_LSB = 4;
    localparam int unsigned SEQ_LEN_LSB     = 16;
    localparam int unsigned TRIG_EN_BIT     = 4;
    localparam int unsigned FLAG_EOC_BIT    = 0;
    localparam int unsigned FLAG_EOS_BIT    = 1;
    localparam int unsigned FLAG_READY_BIT  = 2;

    // Reset values
    localparam logic [3:0] CH_RST        = 4'h0;
    localparam logic [2:0] MODE_RST      = 3'h0;
    localparam logic [1:0] SEQ_LEN_RST   = 2'h0;

    // Mode codes
    localparam logic [2:0] MODE_SINGLE_CONT = 3'h2;
    localparam logic [2:0] MODE_SEQ_CONT    = 3'h3;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_WAIT = 2'b10
    } acs_seq_state_t;
endpackage : acs_pkg

// ### core/acs_seq.sv
// Conversion sequencer: launches conversions and routes results to slots
`timescale 1ns/1ps
`default_nettype none
module acs_seq (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        ce,
    input  wire logic                        enable,
    input  wire logic                        run,
    input  wire logic [2:0]                  mode,
    input  wire logic [1:0]                  seq_len,
    input  wire logic [3:0]                  ch_single,
    input  wire logic [3:0][3:0]             slot_ch,
    input  wire logic                        conv_done,
    input  wire logic [11:0]                 conv_data,
    output logic                             conv_start,
    output logic [3:0]                       conv_channel,
    output logic                             busy,
    output logic [1:0]                       slot,
    output logic                             res_we,
    output logic [1:0]                       res_idx,
    output logic [11:0]                      res_data,
    output logic                             eos_p
);
    typedef struct packed {
        acs_pkg::acs_seq_state_t st;
        logic [1:0]              slot;
        logic [3:0]              chan;
        logic                    start_p;
        logic                    res_we;
        logic [1:0]              res_idx;
        logic [11:0]             res_data;
        logic                    eos_p;
    } acs_seq_st_t;

    localparam acs_seq_st_t SEQ_RST = '{acs_pkg::SEQ_IDLE, 2'h0, acs_pkg::CH_RST, 1'b0, 1'b0, 2'h0, 12'h000, 1'b0};

    acs_seq_st_t q_r;
    acs_seq_st_t q_nxt;
    logic        seq_mode;
    logic        go;
    logic        last;
    logic [1:0]  nslot;

    assign seq_mode = (mode == acs_pkg::MODE_SEQ_CONT);
    // R7: both modes run until stop
    assign go       = run && enable && (seq_mode || mode == acs_pkg::MODE_SINGLE_CONT);
    // R6: last active slot
    assign last     = !seq_mode || (q_r.slot >= seq_len);
    assign nslot    = last ? 2'h0 : 2'(q_r.slot + 2'h1);

    always_comb begin
        q_nxt         = q_r;
        q_nxt.start_p = 1'b0;
        q_nxt.res_we  = 1'b0;
        q_nxt.eos_p   = 1'b0;
        case (q_r.st)
            acs_pkg::SEQ_IDLE: begin
                // R1: start on run
                if (go) begin
                    q_nxt.st      = acs_pkg::SEQ_WAIT;
                    q_nxt.start_p = 1'b1;
                    q_nxt.chan    = seq_mode ? slot_ch[q_r.slot] : ch_single;
                end
            end
            acs_pkg::SEQ_WAIT: begin
                if (!enable) begin
                    // Converter switched off mid-conversion: drop the sample
                    q_nxt.st   = acs_pkg::SEQ_IDLE;
                    q_nxt.slot = 2'h0;
                end else if (conv_done) begin
                    // R18: finish current sample
                    q_nxt.res_we   = 1'b1;
                    q_nxt.res_idx  = seq_mode ? q_r.slot : 2'h0;
                    q_nxt.res_data = conv_data;
                    // R9: end of pass
                    q_nxt.eos_p    = seq_mode && last;
                    // R17: wrap to slot zero
                    q_nxt.slot     = nslot;
                    if (go) begin
                        q_nxt.start_p = 1'b1;
                        q_nxt.chan    = seq_mode ? slot_ch[nslot] : ch_single;
                    end else begin
                        q_nxt.st   = acs_pkg::SEQ_IDLE;
                        q_nxt.slot = 2'h0;
                    end
                end
            end
            default: q_nxt = SEQ_RST;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_r <= SEQ_RST;
        end else if (ce) begin
            q_r <= q_nxt;
        end
    end

    assign conv_start   = q_r.start_p;
    assign conv_channel = q_r.chan;
    assign busy         = (q_r.st == acs_pkg::SEQ_WAIT);
    assign slot         = q_r.slot;
    assign res_we       = q_r.res_we;
    assign res_idx      = q_r.res_idx;
    assign res_data     = q_r.res_data;
    assign eos_p        = q_r.eos_p;
endmodule : acs_seq
`default_nettype wire

// ### bench/acs_core_model.sv
// Behavioural model of the analog conversion core facing the controller
`timescale 1ns/1ps
`default_nettype none
module acs_core_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        conv_enable,
    input  wire logic        conv_start,
    input  wire logic [3:0]  conv_channel,
    input  wire logic [3:0]  lat,
    output logic             conv_done,
    output logic [11:0]      conv_data
);
    logic       busy;
    logic [3:0] cnt;
    logic [3:0] ch;
    logic [7:0] seq;

    // Sample carries the channel in its top nibble so routing can be traced
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy      <= 1'b0;
            cnt       <= 4'h0;
            ch        <= 4'h0;
            seq       <= 8'h00;
            conv_done <= 1'b0;
            conv_data <= 12'h000;
        end else begin
            conv_done <= 1'b0;
            // Data is only meaningful with the done pulse; churn it otherwise
            conv_data <= ~conv_data;
            if (!conv_enable) begin
                busy <= 1'b0;
            end else if (conv_start) begin
                busy <= 1'b1;
                cnt  <= lat;
                ch   <= conv_channel;
            end else if (busy && cnt == 4'h0) begin
                busy      <= 1'b0;
                conv_done <= 1'b1;
                conv_data <= {ch, seq};
                seq       <= seq + 8'h01;
            end else if (busy) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule : acs_core_model
`default_nettype wire

// ### bench/acs_ctrl_tb.sv
// Self-checking testbench for the continuous conversion controller
`timescale 1ns/1ps
`default_nettype none
module acs_ctrl_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        conv_enable, conv_start, conv_done, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, cfg;
    logic [15:0] trig_in;
    logic [3:0]  conv_channel, conv_sample_speed, lat;
    logic [11:0] conv_data;
    logic [3:0]  chq[$];
    int          fails = 0, tests_run = 0, cyc = 0, n_done = 0, k, n, s;

    acs_ctrl i_acs_ctrl (.pclk(pclk), .presetn(presetn), .ce(1'b1), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trig_in(trig_in), .conv_enable(conv_enable), .conv_start(conv_start),
        .conv_channel(conv_channel), .conv_sample_speed(conv_sample_speed), .conv_done(conv_done),
        .conv_data(conv_data), .irq(irq));
    acs_core_model i_acs_core_model (.pclk(pclk), .presetn(presetn), .conv_enable(conv_enable),
        .conv_start(conv_start), .conv_channel(conv_channel), .lat(lat), .conv_done(conv_done),
        .conv_data(conv_data));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Request held from setup until the edge that samples pready high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench timeout ends this wait
        do @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask : wr

    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        check(name, rd, exp);
    endtask : rdchk

    task automatic wait_n(input int m);
        while (chq.size() < m) @(posedge pclk);
    endtask : wait_n

    always @(negedge pclk) begin
        if (conv_start === 1'b1) chq.push_back(conv_channel);
        if (conv_done === 1'b1) n_done++;
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            complete_run();
        end
    end

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; trig_in = 16'h0000; lat = 4'h1;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk("ctrl0 reset", acs_pkg::OFF_CTRL0, 32'h0);
        rdchk("flags reset", acs_pkg::OFF_FLAG, 32'h0);
        apb(8'h30, 1'b0, 32'h0);
        check("unmapped err", 32'(err), 32'h1);
        check("unmapped data", rd, 32'h0);
        wr(acs_pkg::OFF_CTRL0, 32'h1);
        do apb(acs_pkg::OFF_FLAG, 1'b0, 32'h0);
        while (rd[acs_pkg::FLAG_READY_BIT] !== 1'b1);
        // mode, flags and channel before start
        wr(acs_pkg::OFF_IRQ_EN, 32'h1);
        wr(acs_pkg::OFF_FLAG_CLR, 32'h0);
        wr(acs_pkg::OFF_CTRL1, 32'h9);
        wr(acs_pkg::OFF_CTRL0, (32'h5 << acs_pkg::CTRL0_SPEED_LSB)
            | (32'(acs_pkg::MODE_SINGLE_CONT) << acs_pkg::CTRL0_MODE_LSB) | 32'h1);
        chq.delete();
        wr(acs_pkg::OFF_START, 32'h1);
        wait_n(4);
        rdchk("start held", acs_pkg::OFF_START, 32'h1);
        apb(acs_pkg::OFF_RESULT0, 1'b0, 32'h0);
        check("result0 channel", 32'(rd[11:8]), 32'h9);
        for (k = 0; k < chq.size(); k++) check("mode2 channel", 32'(chq[k]), 32'h9);
        @(negedge pclk);
        check("speed", 32'(conv_sample_speed), 32'h5);
        check("irq raised", 32'(irq), 32'h1);
        @(posedge pclk);
        wr(acs_pkg::OFF_IRQ_EN, 32'h0);
        @(negedge pclk);
        check("irq masked", 32'(irq), 32'h0);
        @(posedge pclk);
        wr(acs_pkg::OFF_IRQ_EN, 32'h1);
        // slow core so a conversion is in flight at stop
        lat <= 4'h9;
        wait_n(chq.size() + 1);
        wr(acs_pkg::OFF_START, 32'h0);
        n = chq.size();
        repeat (40) @(posedge pclk);
        check("no launch after stop", 32'(chq.size()), 32'(n));
        check("last conversion done", 32'(n_done), 32'(n));
        wr(acs_pkg::OFF_FLAG_CLR, 32'h0);
        rdchk("flags cleared", acs_pkg::OFF_FLAG, 32'h4);
        @(negedge pclk);
        check("irq cleared", 32'(irq), 32'h0);
        @(posedge pclk);
        for (s = 0; s < 4; s++) begin
            lat <= s[0] ? 4'h6 : 4'h0;
            cfg = 32'(s) << acs_pkg::SEQ_LEN_LSB;
            for (k = 0; k < 4; k++) cfg = cfg | (32'(4 * s + k) << (4 * k));
            wr(acs_pkg::OFF_SEQ_CFG, cfg);
            wr(acs_pkg::OFF_CTRL0, (32'(acs_pkg::MODE_SEQ_CONT) << acs_pkg::CTRL0_MODE_LSB) | 32'h1);
            // flags cleared before the sequence run
            wr(acs_pkg::OFF_FLAG_CLR, 32'h0);
            chq.delete();
            wr(acs_pkg::OFF_START, 32'h1);
            wait_n(2 * (s + 1) + 1);
            wr(acs_pkg::OFF_START, 32'h0);
            repeat (30) @(posedge pclk);
            for (k = 0; k < 2 * (s + 1); k++)
                check("slot channel", 32'(chq[k]), 32'(4 * s + k % (s + 1)));
            rdchk("eoc eos flags", acs_pkg::OFF_FLAG, 32'h7);
            // results read before any later run overwrites them
            for (k = 0; k <= s; k++) begin
                apb(acs_pkg::OFF_RESULT0 + 8'(4 * k), 1'b0, 32'h0);
                check("slot result", 32'(rd[11:8]), 32'(4 * s + k));
            end
        end
        // Sequence-done flag alone must raise the interrupt
        wr(acs_pkg::OFF_IRQ_EN, 32'h2);
        @(negedge pclk);
        check("eos irq", 32'(irq), 32'h1);
        @(posedge pclk);
        wr(acs_pkg::OFF_CTRL0, (32'(acs_pkg::MODE_SINGLE_CONT) << acs_pkg::CTRL0_MODE_LSB) | 32'h1);
        wr(acs_pkg::OFF_TRIG_CFG, 32'h17);
        chq.delete();
        trig_in <= 16'h0080;
        wait_n(2);
        rdchk("trigger start", acs_pkg::OFF_START, 32'h1);
        check("trigger channel", 32'(chq[0]), 32'h9);
        trig_in <= 16'h0000;
        wr(acs_pkg::OFF_START, 32'h0);
        repeat (30) @(posedge pclk);
        wr(acs_pkg::OFF_CTRL0, 32'h0);
        apb(acs_pkg::OFF_FLAG, 1'b0, 32'h0);
        check("ready dropped", 32'(rd[acs_pkg::FLAG_READY_BIT]), 32'h0);
        check("core disabled", 32'(conv_enable), 32'h0);
        complete_run();
    end
endmodule : acs_ctrl_tb
`default_nettype wire
